// [rcspc_top.v]
// reset cause and sleep power control with wishbone register slave
`timescale 1ns/1ps
`default_nettype none
`include "rcspc_map.vh"
module rcspc_top (
  input wire clk,
  input wire arst_n,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire wd0_reset_req,
  input wire wd1_reset_req,
  input wire brownout_core,
  input wire brownout_analog,
  input wire external_reset_pin_n,
  input wire hib_reset_req,
  input wire hw_service_req,
  input wire sleep_req,
  input wire [31:0] periph_run_en,
  input wire [31:0] periph_sleep_en,
  output reg [31:0] periph_clk_en,
  output reg full_por_req,
  output reg sys_reset_n,
  output reg sleep_flash_reduced,
  output reg [1:0] sleep_sram_mode,
  output reg usb_phy_pll_on,
  output reg usb_phy_enable,
  output reg brownout_irq,
  output reg brownout_nmi
);
  // arst_n is the power-on reset; a system reset only restores defaults
  reg [3:0] act_q;
  reg [7:0] cause_q;
  reg [3:0] sleep_q;
  reg usb_q;
  reg [3:0] vcfg_q;
  reg [1:0] vstat_q;
  reg [3:0] rcnt_q;
  reg full_q;
  reg bo_core_q;
  reg bo_ana_q;
  wire wr;
  wire rd;
  wire bo_core_ev;
  wire bo_ana_ev;
  wire bo_rst;
  wire sw_rst;
  wire pin_ev;
  wire [3:0] src_ev;
  wire sys_ev;
  wire por_ev;
  wire in_rst;
  reg pin_d1_q;
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
  assign rd = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign sw_rst = wr & (wb_adr_i == `RCSPC_ADR_SWRST) & wb_dat_i[0];
  assign bo_core_ev = brownout_core & ~bo_core_q;
  assign bo_ana_ev = brownout_analog & ~bo_ana_q;
  // brown-out reset only when the rail's response selects it
  assign bo_rst = ve_hit(bo_core_ev, vcfg_q[1:0], bo_ana_ev, vcfg_q[3:2], `RCSPC_VE_RST);
  assign pin_ev = ~external_reset_pin_n & pin_d1_q;
  assign src_ev = {pin_ev, bo_rst, wd1_reset_req, wd0_reset_req};
  // each watchdog, brown-out and pin source routed by its own action bit
  assign por_ev = |(src_ev & act_q);
  assign sys_ev = (|(src_ev & ~act_q)) | sw_rst | hib_reset_req | hw_service_req;
  assign in_rst = (rcnt_q != 4'h0);

  function [3:0] act_merge;
    input [3:0] cur;
    input [7:0] req;
    integer i;
    begin
      act_merge = cur;
      for (i = 0; i < 4; i = i + 1)
      begin
        if (req[2*i])
          act_merge[i] = 1'b1;
        else if (req[2*i+1])
          act_merge[i] = 1'b0;
      end
    end
  endfunction

  // either rail's new event with its response set to the given code
  function ve_hit;
    input ev_a;
    input [1:0] cfg_a;
    input ev_b;
    input [1:0] cfg_b;
    input [1:0] code;
    begin
      ve_hit = (ev_a & (cfg_a == code)) | (ev_b & (cfg_b == code));
    end
  endfunction

  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      bo_core_q <= 1'b0;
      bo_ana_q <= 1'b0;
      // idle level of the pin, so no false edge after reset
      pin_d1_q <= 1'b1;
      act_q <= `RCSPC_ACT_RESET;
      vstat_q <= 2'h0;
      cause_q <= `RCSPC_POR_CAUSE;
      rcnt_q <= 4'h0;
      full_q <= 1'b0;
    end
    else
    begin
      bo_core_q <= brownout_core;
      bo_ana_q <= brownout_analog;
      pin_d1_q <= external_reset_pin_n;
      // brown-out flags: set wins over clear, never reset by system reset
      vstat_q[`RCSPC_VS_CORE] <= bo_core_ev | (vstat_q[`RCSPC_VS_CORE] &
        ~(wr & (wb_adr_i == `RCSPC_ADR_VESTAT) & wb_dat_i[`RCSPC_VS_CORE]));
      vstat_q[`RCSPC_VS_ANA] <= bo_ana_ev | (vstat_q[`RCSPC_VS_ANA] &
        ~(wr & (wb_adr_i == `RCSPC_ADR_VESTAT) & wb_dat_i[`RCSPC_VS_ANA]));
      if (por_ev)
      begin
        // full power-on sequence reloads action and cause as power-on reset does; brown-out flags are kept
        act_q <= `RCSPC_ACT_RESET;
        cause_q <= `RCSPC_POR_CAUSE;
        full_q <= 1'b1;
        rcnt_q <= `RCSPC_RST_CYCLES;
      end
      else
      begin
        if (wr & (wb_adr_i == `RCSPC_ADR_ACTSET) & ~in_rst)
          act_q <= act_merge(act_q, wb_dat_i[7:0]);
        // causes accumulate; clear only masked bits; new event wins
        cause_q <= (cause_q & ~((wr & (wb_adr_i == `RCSPC_ADR_CAUSECLR)) ?
          wb_dat_i[7:0] : 8'h00)) |
          {hw_service_req, hib_reset_req, wd1_reset_req, sw_rst,
           wd0_reset_req, bo_rst, 1'b0, pin_ev};
        if (sys_ev)
        begin
          rcnt_q <= `RCSPC_RST_CYCLES;
          full_q <= 1'b0;
        end
        else if (in_rst)
          rcnt_q <= rcnt_q - 4'h1;
        else
          full_q <= 1'b0;
      end
    end
  end

  // registers restored to defaults by any reset
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sleep_q <= `RCSPC_SLEEP_RESET;
      usb_q <= 1'b0;
      vcfg_q <= `RCSPC_VE_RESET;
    end
    else if (in_rst)
    begin
      sleep_q <= `RCSPC_SLEEP_RESET;
      usb_q <= 1'b0;
      vcfg_q <= `RCSPC_VE_RESET;
    end
    else if (wr)
    begin
      if (wb_adr_i == `RCSPC_ADR_SLEEP)
        sleep_q <= wb_dat_i[3:0];
      if (wb_adr_i == `RCSPC_ADR_USB)
        usb_q <= wb_dat_i[0];
      if (wb_adr_i == `RCSPC_ADR_VEVCFG)
        vcfg_q <= wb_dat_i[3:0];
    end
  end

  // bus answer one cycle after request, unmapped reads return zero
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= rd;
      wb_dat_o <= 32'h0000_0000;
      if (rd & ~wb_we_i)
      begin
        case (wb_adr_i)
          `RCSPC_ADR_ACT: wb_dat_o <= {28'h000_0000, act_q};
          `RCSPC_ADR_CAUSE: wb_dat_o <= {24'h00_0000, cause_q};
          `RCSPC_ADR_SLEEP: wb_dat_o <= {28'h000_0000, sleep_q};
          `RCSPC_ADR_SRAMSZ: wb_dat_o <= `RCSPC_SRAM_BYTES;
          `RCSPC_ADR_USB: wb_dat_o <= {31'h0000_0000, usb_q};
          `RCSPC_ADR_VEVCFG: wb_dat_o <= {28'h000_0000, vcfg_q};
          `RCSPC_ADR_VESTAT: wb_dat_o <= {30'h0000_0000, vstat_q};
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      periph_clk_en <= 32'h0000_0000;
      full_por_req <= 1'b0;
      sys_reset_n <= 1'b0;
      sleep_flash_reduced <= 1'b0;
      sleep_sram_mode <= `RCSPC_SRAM_FULL;
      usb_phy_pll_on <= 1'b0;
      usb_phy_enable <= 1'b0;
      brownout_irq <= 1'b0;
      brownout_nmi <= 1'b0;
    end
    else
    begin
      if (sleep_req & sleep_q[0])
        periph_clk_en <= periph_run_en & periph_sleep_en;
      else
        periph_clk_en <= periph_run_en;
      full_por_req <= full_q & in_rst;
      sys_reset_n <= ~in_rst & ~sys_ev & ~por_ev;
      sleep_flash_reduced <= sleep_req & sleep_q[1];
      sleep_sram_mode <= sleep_req ? sleep_q[3:2] : `RCSPC_SRAM_FULL;
      usb_phy_pll_on <= usb_q;
      usb_phy_enable <= usb_q;
      brownout_irq <= ve_hit(bo_core_ev, vcfg_q[1:0], bo_ana_ev, vcfg_q[3:2], `RCSPC_VE_INT);
      brownout_nmi <= ve_hit(bo_core_ev, vcfg_q[1:0], bo_ana_ev, vcfg_q[3:2], `RCSPC_VE_NMI);
    end
  end
endmodule
`default_nettype wire

// [rcspc_map.vh]
// register offsets, field positions, reset values and timing counts
`ifndef RCSPC_MAP_VH
`define RCSPC_MAP_VH
`define RCSPC_ADR_SWRST 8'h00
`define RCSPC_ADR_ACTSET 8'h04
`define RCSPC_ADR_ACT 8'h08
`define RCSPC_ADR_CAUSE 8'h0C
`define RCSPC_ADR_CAUSECLR 8'h10
`define RCSPC_ADR_SLEEP 8'h14
`define RCSPC_ADR_SRAMSZ 8'h18
`define RCSPC_ADR_USB 8'h1C
`define RCSPC_ADR_VEVCFG 8'h20
`define RCSPC_ADR_VESTAT 8'h24
`define RCSPC_SWRST_KEY 32'h0000_0001
// action register: bit0 wd0, 1 wd1, 2 brownout, 3 pin; 1 = full por
`define RCSPC_ACT_RESET 4'h0
// action set: bits 2n = full por, 2n+1 = system, source n
// cause bits
`define RCSPC_C_EXT 0
`define RCSPC_C_POR 1
`define RCSPC_C_BOR 2
`define RCSPC_C_WD0 3
`define RCSPC_C_SW 4
`define RCSPC_C_WD1 5
`define RCSPC_C_HIB 6
`define RCSPC_C_HSR 7
`define RCSPC_POR_CAUSE 8'h02
// sleep register: bit0 gating, bit1 flash reduced, bits3:2 sram mode
`define RCSPC_SRAM_FULL 2'h0
`define RCSPC_SRAM_STBY 2'h1
`define RCSPC_SRAM_LOW 2'h3
`define RCSPC_SLEEP_RESET 4'h0
// voltage event config: bits1:0 core rail, 3:2 analog rail
`define RCSPC_VE_NONE 2'h0
`define RCSPC_VE_INT 2'h1
`define RCSPC_VE_NMI 2'h2
`define RCSPC_VE_RST 2'h3
`define RCSPC_VE_RESET 4'h0
`define RCSPC_VS_CORE 0
`define RCSPC_VS_ANA 1
`define RCSPC_SRAM_BYTES 32'h0000_8000
`define RCSPC_RST_CYCLES 4'h8
`endif

// [rcspc_props.sv]
// port checker for bus timing, reset windows and sleep outputs
`timescale 1ns/1ps
`default_nettype none
module rcspc_props (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic wd0_reset_req,
  input wire logic sleep_req,
  input wire logic [31:0] periph_run_en,
  input wire logic [31:0] periph_clk_en,
  input wire logic sys_reset_n,
  input wire logic sleep_flash_reduced,
  input wire logic [1:0] sleep_sram_mode,
  input wire logic usb_phy_pll_on,
  input wire logic usb_phy_enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_win;
    !sys_reset_n [*8];
  endsequence
  a_ack_resp: assert property (s_req |=> wb_ack_o)
    else $error("ack missing");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("data without ack");
  a_wd0_window: assert property (wd0_reset_req |=> s_win)
    else $error("reset window short");
  a_flash_awake: assert property (!sleep_req |=> !sleep_flash_reduced)
    else $error("flash reduced awake");
  a_sram_awake: assert property (!sleep_req |=> sleep_sram_mode == 2'h0)
    else $error("sram reduced awake");
  a_clk_awake: assert property (!sleep_req |=> periph_clk_en == $past(periph_run_en))
    else $error("clock gated awake");
  a_usb_phy: assert property (!usb_phy_pll_on |-> !usb_phy_enable)
    else $error("phy without pll");
endmodule
bind rcspc_top rcspc_props chk_u (.*);
`default_nettype wire

// [rcspc_top_tb_top.sv]
// self-checking bench for reset cause and sleep power control
`timescale 1ns/1ps
`default_nettype none
module rcspc_top_tb_top;
  typedef struct {logic [7:0] wa; logic [31:0] wd; logic [7:0] ra; logic [31:0] ex;} rcspc_row_t;
  logic clk = 1'b0, arst_n = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h0;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, periph_run_en = 32'hFFFF_0000, periph_sleep_en = 32'h0F0F_0F0F;
  logic [31:0] wb_dat_o, periph_clk_en, q;
  logic wd0_reset_req = 1'b0, wd1_reset_req = 1'b0, hib_reset_req = 1'b0, hw_service_req = 1'b0;
  logic brownout_core = 1'b0, brownout_analog = 1'b0, external_reset_pin_n = 1'b1, sleep_req = 1'b0;
  logic wb_ack_o, full_por_req, sys_reset_n, sleep_flash_reduced, usb_phy_pll_on, usb_phy_enable;
  logic brownout_irq, brownout_nmi;
  logic [1:0] sleep_sram_mode, bo = 2'h0;
  logic [1:0] sm [3] = '{2'h0, 2'h1, 2'h3};
  int mismatches = 0, checks = 0;
  rcspc_row_t rows [6] = '{
    '{8'h04, 32'h41, 8'h08, 32'h9},
    '{8'h04, 32'h22, 8'h08, 32'h8},
    '{8'h14, 32'hD, 8'h14, 32'hD},
    '{8'h1C, 32'h1, 8'h1C, 32'h1},
    '{8'h18, 32'h0, 8'h18, 32'h8000},
    '{8'h3C, 32'h5, 8'h3C, 32'h0}};
  always #5 clk = ~clk;
  rcspc_top dut_u (.*);
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    checks++;
    if (seen !== ex)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, ex, seen);
    end
  endtask
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do
      @(posedge clk);
    while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] ex);
    bus(1'b0, a, 32'h0);
    chk(nm, q, ex);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    rc("cause", 8'h0C, 32'h2);
    rc("action", 8'h08, 32'h0);
    foreach (rows[i])
    begin
      bus(1'b1, rows[i].wa, rows[i].wd);
      rc("row", rows[i].ra, rows[i].ex);
    end
    bus(1'b1, 8'h10, 32'hFF);
    rc("cleared", 8'h0C, 32'h0);
    wd0_reset_req <= 1'b1;
    wd1_reset_req <= 1'b1;
    hib_reset_req <= 1'b1;
    hw_service_req <= 1'b1;
    @(posedge clk);
    wd0_reset_req <= 1'b0;
    wd1_reset_req <= 1'b0;
    hib_reset_req <= 1'b0;
    hw_service_req <= 1'b0;
    repeat (2) @(posedge clk);
    chk("sys window", {31'h0, sys_reset_n}, 32'h0);
    chk("no full por", {31'h0, full_por_req}, 32'h0);
    repeat (10) @(posedge clk);
    bus(1'b1, 8'h00, 32'h1);
    repeat (12) @(posedge clk);
    rc("multi", 8'h0C, 32'hF8);
    rc("sleep sys", 8'h14, 32'h0);
    bus(1'b1, 8'h10, 32'h10);
    rc("masked", 8'h0C, 32'hE8);
    bus(1'b1, 8'h20, 32'h9);
    brownout_core <= 1'b1;
    brownout_analog <= 1'b1;
    repeat (4)
    begin
      @(posedge clk);
      bo = bo | {brownout_irq, brownout_nmi};
    end
    chk("responses", {30'h0, bo}, 32'h3);
    rc("vestat", 8'h24, 32'h3);
    bus(1'b1, 8'h24, 32'h1);
    rc("vestat clr", 8'h24, 32'h2);
    external_reset_pin_n <= 1'b0;
    @(posedge clk);
    external_reset_pin_n <= 1'b1;
    repeat (2) @(posedge clk);
    chk("full por", {31'h0, full_por_req}, 32'h1);
    chk("por window", {31'h0, sys_reset_n}, 32'h0);
    repeat (10) @(posedge clk);
    rc("por cause", 8'h0C, 32'h2);
    rc("por action", 8'h08, 32'h0);
    rc("vestat kept", 8'h24, 32'h2);
    chk("usb off", {31'h0, usb_phy_enable}, 32'h0);
    chk("pll off", {31'h0, usb_phy_pll_on}, 32'h0);
    bus(1'b1, 8'h14, 32'h1);
    sleep_req <= 1'b1;
    repeat (3) @(posedge clk);
    chk("gated", periph_clk_en, 32'h0F0F_0000);
    foreach (sm[i])
    begin
      bus(1'b1, 8'h14, {28'h0, sm[i], 2'b10});
      repeat (2) @(posedge clk);
      chk("sram", {30'h0, sleep_sram_mode}, {30'h0, sm[i]});
      chk("flash", {31'h0, sleep_flash_reduced}, 32'h1);
      chk("ungated", periph_clk_en, 32'hFFFF_0000);
    end
    sleep_req <= 1'b0;
    conclude();
  end
  initial
  begin
    repeat (3000) @(posedge clk);
    mismatches++;
    conclude();
  end
endmodule
`default_nettype wire
